// ===== hdl/ips_map.svh
// constants of the program sequencer: timing, frame layout, reset values
`ifndef IPS_MAP_SVH
`define IPS_MAP_SVH

// system clock rate
`define IPS_CLK_MHZ         200
// pin transition windows and pulse times
`define IPS_ENTER_TIME_US   1000
`define IPS_EXIT_TIME_US    1000
`define IPS_ERASE_TIME_US   100000
`define IPS_PROG_PULSE_NS   1000
`define IPS_READ_PULSE_NS   1000
// serial frame layout, first bit shifted lands in bit 0
`define IPS_FRAME_BITS      5'h18
`define IPS_OP_LSB          0
`define IPS_ADDR_LSB        8
`define IPS_DATA_LSB        16
// storage and reset values
`define IPS_ARRAY_WORDS     16
`define IPS_FIFO_DEPTH      4
`define IPS_ERASED_WORD     8'hFF
`define IPS_ID_DEFAULT      16'h5A3C

`endif

// ===== hdl/ips_pkg.sv
// types shared by the program sequencer
package ips_pkg;

  // gray codes along idle, enter, ready, pulse
  typedef enum logic [2:0] {
    IPS_IDLE  = 3'h0,
    IPS_ENTER = 3'h1,
    IPS_READY = 3'h3,
    IPS_PULSE = 3'h2,
    IPS_EXIT  = 3'h6
  } ips_state_t;

  // serial commands
  typedef enum logic [7:0] {
    IPS_OP_NOP     = 8'h00,
    IPS_OP_ENTER   = 8'h01,
    IPS_OP_IDCODE  = 8'h02,
    IPS_OP_ERASE   = 8'h03,
    IPS_OP_PROGRAM = 8'h04,
    IPS_OP_VERIFY  = 8'h05,
    IPS_OP_EXIT    = 8'h06
  } ips_op_t;

endpackage

// ===== hdl/ips_sequencer.sv
// in-system programming sequencer behind the serial test pins, with its command fifo
`timescale 1ns/1ps
`default_nettype none
`include "ips_map.svh"
// Summary of operation
// - instructions, address, data enter serially; read-back data leaves serially on tdo
// - entry lasts 1 ms, pins move smoothly from user to programming mode
// - device supplies its identifier on request before program or verify
// - after erase command one 100 ms pulse erases the whole array
// - each address: shift address and data, pulse writes those cells
// - each address: shift address, read pulse, cell contents shifted out
// - exit lasts 1 ms, pins return smoothly to user mode

// small first-in first-out buffer
module ips_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             wr;
  logic             rd;

  // wrap at depth so non power of two depths also work
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // handshakes and flags
  assign in_ready  = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign wr        = in_valid & in_ready;
  assign rd        = out_valid & out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (wr) begin
        wr_ptr <= ptr_next(wr_ptr);
      end
      if (rd) begin
        rd_ptr <= ptr_next(rd_ptr);
      end
      if (wr && !rd) begin
        count <= count + 1'b1;
      end else if (rd && !wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ips_fifo

// device side of the programming flow
module ips_sequencer #(
  parameter int unsigned ENTER_CYCLES = `IPS_ENTER_TIME_US * `IPS_CLK_MHZ,
  parameter int unsigned EXIT_CYCLES  = `IPS_EXIT_TIME_US * `IPS_CLK_MHZ,
  parameter int unsigned ERASE_CYCLES = `IPS_ERASE_TIME_US * `IPS_CLK_MHZ,
  // identifier value is arbitrary
  parameter logic [15:0] ID_CODE      = `IPS_ID_DEFAULT
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // serial test pins
  input  wire logic tck,
  input  wire logic tdi,
  input  wire logic shift_sel,
  output logic      tdo,
  // mode and flow status
  output logic      io_prog_mode,
  output logic      prog_ready,
  output logic      cmd_ready
);
  localparam int unsigned PROG_CYCLES = `IPS_PROG_PULSE_NS * `IPS_CLK_MHZ / 1000;
  localparam int unsigned READ_CYCLES = `IPS_READ_PULSE_NS * `IPS_CLK_MHZ / 1000;

  logic [2:0]               pin_s1;
  logic [2:0]               pin_s2;
  logic [2:0]               pin_s3;
  logic [2:0]               pin_q;
  logic [2:0]               pin_prev;
  logic                     tck_rise;
  logic                     tck_fall;
  logic                     sel_q;
  logic                     sel_fall;
  logic [23:0]              shift_in;
  logic [4:0]               bit_cnt;
  logic                     push;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic [23:0]              fifo_out_data;
  logic                     take;
  ips_pkg::ips_op_t         op;
  ips_pkg::ips_state_t      state;
  logic [31:0]              timer;
  ips_pkg::ips_op_t         cur_op;
  logic [3:0]               cur_addr;
  logic [7:0]               cur_data;
  logic                     pulse_end;
  logic [7:0]               cells [`IPS_ARRAY_WORDS];
  logic [15:0]              shift_out;

  // three stage sync; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1   <= 3'h0;
      pin_s2   <= 3'h0;
      pin_s3   <= 3'h0;
      pin_q    <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_s1   <= {shift_sel, tdi, tck};
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_q    <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
      pin_prev <= pin_q;
    end
  end

  // filtered edges of the test clock and frame select
  assign tck_rise = pin_q[0] & ~pin_prev[0];
  assign tck_fall = ~pin_q[0] & pin_prev[0];
  assign sel_q    = pin_q[2];
  assign sel_fall = ~pin_q[2] & pin_prev[2];

  // serial frame capture
  // count saturates so an overlong frame never matches and is dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_in <= 24'h000000;
      bit_cnt  <= 5'h00;
    end else if (sel_q && tck_rise) begin
      shift_in <= {pin_q[1], shift_in[23:1]};
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end else if (!sel_q) begin
      bit_cnt <= 5'h00;
    end
  end

  // a whole frame is queued when the select drops, unless the fifo is full
  assign push = sel_fall && (bit_cnt == `IPS_FRAME_BITS);

  // commands wait here while a long pulse runs
  ips_fifo #(
    .WIDTH (24),
    .DEPTH (`IPS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_in),
    .out_valid (fifo_out_valid),
    .out_ready (take),
    .out_data  (fifo_out_data)
  );

  // programmer must hold off new frames while this is low
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= fifo_in_ready;
    end
  end

  // drain stalls during timed windows, which lets the fifo fill
  assign take = fifo_out_valid
             && (state == ips_pkg::IPS_IDLE || state == ips_pkg::IPS_READY);
  assign op   = ips_pkg::ips_op_t'(fifo_out_data[`IPS_OP_LSB +: 8]);
  assign pulse_end = (state == ips_pkg::IPS_PULSE) && (timer == 32'h00000000);

  // flow state, window timer and pin mode
  always_ff @(posedge clk) begin
    if (reset) begin
      state        <= ips_pkg::IPS_IDLE;
      timer        <= 32'h00000000;
      io_prog_mode <= 1'b0;
      prog_ready   <= 1'b0;
      cur_op       <= ips_pkg::IPS_OP_NOP;
      cur_addr     <= 4'h0;
      cur_data     <= 8'h00;
    end else begin
      if (timer != 32'h00000000) begin
        timer <= timer - 32'h00000001;
      end
      unique case (state)
        ips_pkg::IPS_IDLE: begin
          // pins leave user mode at the start of entry
          if (take && op == ips_pkg::IPS_OP_ENTER) begin
            state        <= ips_pkg::IPS_ENTER;
            timer        <= 32'(ENTER_CYCLES - 1);
            io_prog_mode <= 1'b1;
          end
        end
        ips_pkg::IPS_ENTER: begin
          // commands accepted only after the full window
          if (timer == 32'h00000000) begin
            state      <= ips_pkg::IPS_READY;
            prog_ready <= 1'b1;
          end
        end
        ips_pkg::IPS_READY: begin
          if (take) begin
            cur_op   <= op;
            cur_addr <= fifo_out_data[`IPS_ADDR_LSB +: 4];
            cur_data <= fifo_out_data[`IPS_DATA_LSB +: 8];
            unique case (op)
              ips_pkg::IPS_OP_ERASE: begin
                state <= ips_pkg::IPS_PULSE;
                timer <= 32'(ERASE_CYCLES - 1);
              end
              ips_pkg::IPS_OP_PROGRAM: begin
                state <= ips_pkg::IPS_PULSE;
                timer <= 32'(PROG_CYCLES - 1);
              end
              ips_pkg::IPS_OP_VERIFY: begin
                state <= ips_pkg::IPS_PULSE;
                timer <= 32'(READ_CYCLES - 1);
              end
              ips_pkg::IPS_OP_EXIT: begin
                state      <= ips_pkg::IPS_EXIT;
                timer      <= 32'(EXIT_CYCLES - 1);
                prog_ready <= 1'b0;
              end
              default: begin
              end
            endcase
          end
        end
        ips_pkg::IPS_PULSE: begin
          if (timer == 32'h00000000) begin
            state <= ips_pkg::IPS_READY;
          end
        end
        ips_pkg::IPS_EXIT: begin
          // pins return to user mode only after the window
          if (timer == 32'h00000000) begin
            state        <= ips_pkg::IPS_IDLE;
            io_prog_mode <= 1'b0;
          end
        end
        default: begin
          state <= ips_pkg::IPS_IDLE;
        end
      endcase
    end
  end

  // nonvolatile array, erased by reset; otherwise cells change only at the end of a pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `IPS_ARRAY_WORDS; i++) begin
        cells[i] <= `IPS_ERASED_WORD;
      end
    end else if (pulse_end && cur_op == ips_pkg::IPS_OP_ERASE) begin
      for (int i = 0; i < `IPS_ARRAY_WORDS; i++) begin
        cells[i] <= `IPS_ERASED_WORD;
      end
    end else if (pulse_end && cur_op == ips_pkg::IPS_OP_PROGRAM) begin
      cells[cur_addr] <= cur_data;
    end
  end

  // read-back register; a load wins over a shift in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_out <= 16'h0000;
      tdo       <= 1'b0;
    end else if (take && state == ips_pkg::IPS_READY && op == ips_pkg::IPS_OP_IDCODE) begin
      shift_out <= ID_CODE;
    end else if (pulse_end && cur_op == ips_pkg::IPS_OP_VERIFY) begin
      shift_out <= {8'h00, cells[cur_addr]};
    end else if (sel_q && tck_fall) begin
      // one bit out per falling test clock edge
      tdo       <= shift_out[0];
      shift_out <= {1'b0, shift_out[15:1]};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_frame_length: assert property (push && fifo_in_ready |=> fifo_out_valid)
    else $error("whole frame not queued");
  a_tdo_shift: assert property (sel_q && tck_fall && !take && !pulse_end
    |=> tdo == $past(shift_out[0]))
    else $error("tdo does not follow read-back register");
  a_enter_start: assert property ($rose(state == ips_pkg::IPS_ENTER)
    |-> io_prog_mode && !prog_ready)
    else $error("entry window without programming pin mode");
  a_enter_done: assert property (state == ips_pkg::IPS_ENTER && timer == 32'h00000000
    |=> state == ips_pkg::IPS_READY && prog_ready)
    else $error("entry window did not end in ready");
  a_id_supply: assert property (take && state == ips_pkg::IPS_READY
    && op == ips_pkg::IPS_OP_IDCODE |=> shift_out == ID_CODE)
    else $error("identifier not loaded");
  a_erase_all: assert property (pulse_end && cur_op == ips_pkg::IPS_OP_ERASE
    |=> cells[0] == `IPS_ERASED_WORD && cells[15] == `IPS_ERASED_WORD)
    else $error("array not erased after pulse");
  a_prog_write: assert property (pulse_end && cur_op == ips_pkg::IPS_OP_PROGRAM
    |=> cells[$past(cur_addr)] == $past(cur_data))
    else $error("programmed cell holds wrong data");
  a_verify_read: assert property (pulse_end && cur_op == ips_pkg::IPS_OP_VERIFY
    |=> shift_out[7:0] == $past(cells[cur_addr]) && state == ips_pkg::IPS_READY)
    else $error("read pulse did not present cell contents");
  a_exit_done: assert property (state == ips_pkg::IPS_EXIT && timer == 32'h00000000
    |=> !io_prog_mode && state == ips_pkg::IPS_IDLE)
    else $error("pins not back in user mode after exit");

  c_enter_done: cover property (state == ips_pkg::IPS_ENTER ##1 state == ips_pkg::IPS_READY);
  c_erase_end: cover property (pulse_end && cur_op == ips_pkg::IPS_OP_ERASE);
  c_verify_end: cover property (pulse_end && cur_op == ips_pkg::IPS_OP_VERIFY);
  c_fifo_full: cover property (!fifo_in_ready);
endmodule // ips_sequencer
`default_nettype wire

// ===== test/ips_programmer_model.sv
// programmer-side model that frames commands onto the serial test pins
`timescale 1ns/1ps
`default_nettype none
module ips_programmer_model (
  // pacing clock
  input  wire logic clk,
  // serial test pins
  output logic      tck,
  output logic      tdi,
  output logic      shift_sel,
  input  wire logic tdo
);
  localparam int HALF = 16; // half of a 160 ns link period

  // link periods spent in frames, the programmer's shift budget
  int link_cycles;

  // link clock stands low outside frames
  initial begin
    tck       = 1'b0;
    tdi       = 1'b0;
    shift_sel = 1'b0;
    link_cycles = 0;
  end

  // serial shift both ways
  // lsb first; read-back bit k is taken at the rise after the (k+1)th fall
  task automatic frame(input logic [23:0] word, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    // select low long enough that the pin filter sees the gap between frames
    repeat (HALF) @(negedge clk);
    shift_sel = 1'b1;
    repeat (HALF) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      tdi = word[i];
      repeat (HALF) @(negedge clk);
      tck = 1'b1;
      if (i >= 1 && i <= 16) rd[i-1] = tdo;
      repeat (HALF) @(negedge clk);
      tck = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    shift_sel = 1'b0;
    // a released data line must not keep showing the last bit
    tdi = ~tdi;
    // gap, set-up and tail round up to two link periods
    link_cycles += nbits + 2;
  endtask
endmodule // ips_programmer_model
`default_nettype wire

// ===== test/ips_sequencer_test.sv
// self-checking bench of the program sequencer against a programmer model
`timescale 1ns/1ps
`default_nettype none
module ips_sequencer_test;
  localparam int unsigned ENTER_N = 50;
  localparam int unsigned EXIT_N  = 50;
  localparam int unsigned ERASE_N = 6000; // long enough to back up the fifo
  localparam logic [15:0] ID_VAL  = 16'hC35A; // arbitrary identifier value
  localparam int          LIMIT   = 60000; // all scenarios take about 45000 cycles
  // fixed pulse and window waits of each flow, in clock cycles
  localparam int          PROG_FIXED = ENTER_N + EXIT_N + ERASE_N + 3330;
  localparam int          VER_FIXED  = ENTER_N + EXIT_N + 320;

  logic        clk;
  logic        reset;
  logic        tck;
  logic        tdi;
  logic        shift_sel;
  logic        tdo;
  logic        io_prog_mode;
  logic        prog_ready;
  logic        cmd_ready;
  logic [15:0] rd;
  int          error_cnt;
  int          checked;
  int          cycles;
  int          n;
  int          t0;
  int          l0;

  ips_sequencer #(
    .ENTER_CYCLES(ENTER_N),
    .EXIT_CYCLES (EXIT_N),
    .ERASE_CYCLES(ERASE_N),
    .ID_CODE     (ID_VAL)
  ) dut (
    .clk         (clk),
    .reset       (reset),
    .tck         (tck),
    .tdi         (tdi),
    .shift_sel   (shift_sel),
    .tdo         (tdo),
    .io_prog_mode(io_prog_mode),
    .prog_ready  (prog_ready),
    .cmd_ready   (cmd_ready)
  );

  ips_programmer_model prog (
    .clk      (clk),
    .tck      (tck),
    .tdi      (tdi),
    .shift_sel(shift_sel),
    .tdo      (tdo)
  );

  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] dat);
    prog.frame({dat, adr, op}, 24, rd);
  endtask

  // bounded wait for both status levels, n counts the cycles waited
  task automatic wait_lvl(input logic m, input logic r);
    n = 0;
    while (!(io_prog_mode === m && prog_ready === r) && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic read_cell(input logic [7:0] adr, input logic [7:0] exp);
    cmd(ips_pkg::IPS_OP_VERIFY, adr, 8'h00);
    repeat (300) @(negedge clk);
    cmd(ips_pkg::IPS_OP_NOP, 8'h00, 8'h00);
    check("cell", rd, {8'h00, exp});
  endtask

  task automatic t_reset();
    @(negedge clk);
    check("idle pins", {tdo, io_prog_mode, prog_ready}, 16'h0000);
    repeat (2) @(negedge clk);
    check("room", cmd_ready, 1'b1);
  endtask

  // identifier request in idle is discarded, nothing to read back
  task automatic t_idle_refuse();
    cmd(ips_pkg::IPS_OP_IDCODE, 8'h00, 8'h00);
    repeat (20) @(negedge clk);
    cmd(ips_pkg::IPS_OP_NOP, 8'h00, 8'h00);
    check("idle read", rd, 16'h0000);
    check("idle mode", io_prog_mode, 1'b0);
  endtask

  task automatic t_enter_ident();
    cmd(ips_pkg::IPS_OP_ENTER, 8'h00, 8'h00);
    wait_lvl(1'b1, 1'b0);
    wait_lvl(1'b1, 1'b1);
    check("enter window", n[15:0], ENTER_N[15:0]);
    cmd(ips_pkg::IPS_OP_IDCODE, 8'h00, 8'h00);
    repeat (20) @(negedge clk);
    cmd(ips_pkg::IPS_OP_NOP, 8'h00, 8'h00);
    check("ident", rd, ID_VAL);
  endtask

  task automatic t_exit();
    cmd(ips_pkg::IPS_OP_EXIT, 8'h00, 8'h00);
    wait_lvl(1'b1, 1'b0);
    wait_lvl(1'b0, 1'b0);
    check("exit window", n[15:0], EXIT_N[15:0]);
  endtask

  // full flow: a programmed cell is erased, then a burst fills the fifo
  // stages run in order: enter, identify, program, verify, erase, program, verify, exit
  task automatic t_full_flow();
    t0 = cycles;
    l0 = prog.link_cycles;
    t_enter_ident();
    cmd(ips_pkg::IPS_OP_PROGRAM, 8'h03, 8'h00);
    repeat (300) @(negedge clk);
    read_cell(8'h03, 8'h00);
    cmd(ips_pkg::IPS_OP_ERASE, 8'h00, 8'h00);
    cmd(ips_pkg::IPS_OP_PROGRAM, 8'h02, 8'h3C);
    cmd(ips_pkg::IPS_OP_PROGRAM, 8'h0F, 8'hA5);
    cmd(ips_pkg::IPS_OP_PROGRAM, 8'h05, 8'h11);
    cmd(ips_pkg::IPS_OP_PROGRAM, 8'h09, 8'hC4);
    repeat (10) @(negedge clk);
    check("full", cmd_ready, 1'b0);
    cmd(ips_pkg::IPS_OP_PROGRAM, 8'h07, 8'h77);
    repeat (ERASE_N) @(negedge clk);
    prog.frame({8'h00, 8'h06, 8'(ips_pkg::IPS_OP_PROGRAM)}, 23, rd);
    repeat (300) @(negedge clk);
    read_cell(8'h03, 8'hFF);
    read_cell(8'h00, 8'hFF);
    read_cell(8'h02, 8'h3C);
    read_cell(8'h0F, 8'hA5);
    read_cell(8'h05, 8'h11);
    read_cell(8'h09, 8'hC4);
    read_cell(8'h07, 8'hFF);
    read_cell(8'h06, 8'hFF);
    t_exit();
    n = (prog.link_cycles - l0) * 32 + PROG_FIXED;
    check("program time", 16'(cycles - t0 <= n), 16'h0001);
  endtask

  // a part with another identifier is left untouched: straight to exit
  task automatic t_wrong_part();
    t_enter_ident();
    if (rd !== (ID_VAL ^ 16'h00FF)) begin
      t_exit();
    end else begin
      cmd(ips_pkg::IPS_OP_ERASE, 8'h00, 8'h00);
      repeat (ERASE_N) @(negedge clk);
      t_exit();
    end
  endtask

  // verify-only run keeps the pattern of the earlier run
  task automatic t_verify_only();
    t0 = cycles;
    l0 = prog.link_cycles;
    t_enter_ident();
    read_cell(8'h0F, 8'hA5);
    t_exit();
    n = (prog.link_cycles - l0) * 32 + VER_FIXED;
    check("verify time", 16'(cycles - t0 <= n), 16'h0001);
  endtask

  initial begin
    reset     = 1'b1;
    error_cnt = 0;
    checked   = 0;
    cycles    = 0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_idle_refuse();
    t_full_flow();
    t_wrong_part();
    t_verify_only();
    final_report();
  end
endmodule // ips_sequencer_test
`default_nettype wire
